// ===== core/pcs_pkg.sv
// Constants, offsets and field layouts of the configuration-space register bank.
// Assumes dword-aligned configuration accesses with byte-lane enables on the bus clock.
package pcs_pkg;

   // Clock and timing
   localparam int CLK_NS = 8;                          // Bus clock period, ns
   localparam int ROM_ACCESS_NS = 64;                  // Time a ROM byte needs to settle
   localparam int ROM_SYNC_CYC = 2;                    // Two-flop pin synchroniser depth
   localparam int ROM_WAIT_CYC = (ROM_ACCESS_NS + CLK_NS - 1) / CLK_NS + ROM_SYNC_CYC;

   // Register offsets (byte address of the dword; OFS_STATUS is the byte address of a word)
   localparam logic [7:0] OFS_CMD_STATUS = 8'h04;      // Status word lives in bytes 2-3
   localparam logic [7:0] OFS_STATUS = 8'h06;          // Byte offset of the status word
   localparam logic [7:0] OFS_LINE_TIMER = 8'h0c;      // Line size byte 0, hold limit byte 1
   localparam logic [7:0] OFS_BAR0 = 8'h10;            // Control space base
   localparam logic [7:0] OFS_BAR1 = 8'h14;            // Aperture one base
   localparam logic [7:0] OFS_BAR2 = 8'h18;            // Aperture two base
   localparam logic [7:0] OFS_BOARD = 8'h2c;           // Board vendor and board ident codes
   localparam logic [7:0] OFS_CAP_START = 8'h34;       // Capability list start
   localparam logic [7:0] OFS_IRQ = 8'h3c;             // Interrupt routing byte
   localparam logic [7:0] OFS_AGP_REV = 8'h40;         // Cap id, next link, revision
   localparam logic [7:0] OFS_AGP_CMD = 8'h48;         // AGP control word
   localparam logic [7:0] OFS_IND_SEL = 8'h4c;         // Indirect target select
   localparam logic [7:0] OFS_IND_DATA = 8'h50;        // Indirect window word

   // Status word layout
   localparam logic [15:0] STATUS_FIXED = 16'h0280;    // Fast b2b target, medium decode timing
   localparam int ST_TGT_ABORT = 12;                   // Received target abort
   localparam int ST_MST_ABORT = 13;                   // Received master abort
   localparam int STATUS_LANE_LSB = 16;                // Status word position in its dword

   // Capability block
   localparam logic [7:0] CAP_ID_AGP = 8'h02;          // AGP capability id
   localparam logic [7:0] NEXT_LINK_NONE = 8'h00;      // End of capability list
   localparam logic [3:0] AGP_MAJOR_ON = 4'h1;         // Major revision with strap set
   localparam logic [3:0] AGP_MAJOR_OFF = 4'h0;        // Major revision with strap clear
   localparam logic [3:0] AGP_MINOR = 4'h0;            // Minor revision
   localparam int AGP_MAJOR_LSB = 20;                  // Major revision field position
   localparam int AGP_SBA_BIT = 9;                     // Sideband address enable
   localparam int AGP_RQ_LSB = 24;                     // Request queue depth field

   // Base address decode sizes
   localparam int BAR0_SIZE_LOG2 = 17;                 // 128 Kbyte control region
   localparam int APER_SIZE_LOG2 = 23;                 // Aperture size

   // Indirect target select layout
   localparam int IND_REGION_LSB = 24;                 // Region field position
   localparam logic [1:0] IND_REGION_ROM = 2'h3;       // Region code for the ROM

   // ROM identity bytes
   localparam logic [15:0] ROM_VENDOR_LO = 16'hfffc;   // First of four identity bytes

   // Chip identity, arbitrary values
   localparam logic [15:0] CHIP_VENDOR_ID = 16'h1a2b;  // Arbitrary value
   localparam logic [15:0] CHIP_DEVICE_ID = 16'h3c4d;  // Arbitrary value

   // ROM loader states
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_WAIT = 2'b01,
      LD_DONE = 2'b10
   } pcs_ld_state_t;

endpackage

// ===== core/pcs_rom_loader.sv
// ROM identity loader: fetches four identity bytes after reset.
// Assumes the ROM data pins are asynchronous and settle within ROM_ACCESS_NS.
`timescale 1ns/1ps
module pcs_rom_loader import pcs_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] rom_data,
   output logic [15:0] rom_addr,
   output logic rom_rd,
   output logic done,
   output logic [15:0] vendor,
   output logic [15:0] ident
);

   // Whole loader state
   typedef struct packed {
      pcs_ld_state_t st;        // Sequencer state
      logic [1:0] idx;          // Byte index
      logic [7:0] wcnt;         // Settle counter
      logic [7:0] d1;           // Pin sync stage one
      logic [7:0] d2;           // Pin sync stage two
      logic [3:0][7:0] bytes;   // Captured bytes
      logic [15:0] addr;        // ROM address
      logic rd;                 // ROM read strobe
      logic done;               // Load finished pulse
      logic finished;           // Load has run once
   } pcs_ld_t;

   pcs_ld_t r_ff;
   pcs_ld_t nxt_r;

   // Sequencer and capture
   always_comb begin
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      nxt_r.d1 = rom_data;
      nxt_r.d2 = r_ff.d1;
      case (r_ff.st)
         LD_IDLE: begin
            if (start && !r_ff.finished) begin
               // Address FFFC plus index
               nxt_r.addr = ROM_VENDOR_LO | {14'h0000, r_ff.idx};
               nxt_r.rd = 1'b1;
               nxt_r.wcnt = 8'(ROM_WAIT_CYC);
               nxt_r.st = LD_WAIT;
            end
         end
         LD_WAIT: begin
            if (r_ff.wcnt != 8'h00) begin
               nxt_r.wcnt = r_ff.wcnt - 8'h01;
            end else begin
               nxt_r.bytes[r_ff.idx] = r_ff.d2;
               nxt_r.rd = 1'b0;
               nxt_r.idx = r_ff.idx + 2'h1;
               nxt_r.st = (r_ff.idx == 2'h3) ? LD_DONE : LD_IDLE;
            end
         end
         LD_DONE: begin
            nxt_r.done = 1'b1;
            nxt_r.finished = 1'b1;
            nxt_r.st = LD_IDLE;
         end
         default: begin
            nxt_r.st = LD_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rom_addr = r_ff.addr;
   assign rom_rd = r_ff.rd;
   assign done = r_ff.done;
   assign vendor = {r_ff.bytes[1], r_ff.bytes[0]};
   assign ident = {r_ff.bytes[3], r_ff.bytes[2]};

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   rom_order_a: assert property (rom_rd && r_ff.idx == 2'h0 |-> rom_addr == 16'hfffc)
      else $error("First identity byte not fetched from FFFC");

endmodule // pcs_rom_loader

// ===== core/pcs_config_space.sv
// Configuration-space register bank of a graphics controller on a PCI/AGP bus.
// Assumes dword configuration cycles on the bus clock and the master's abort pulses on it.
//
// What this block does
// - Master aborts set status bits 12, 13
// - ROM mode loads vendor from FFFC/FFFD
// - Strap mode: vendor resets to chip, write-once
// - ROM mode loads board ident from FFFE/FFFF
// - Strap mode: ident resets to device, write-once
// - Capability start holds AGP block offset
// - Next capability link reads zero
// - AGP major revision follows strap; minor zero
// - Control bit 9 switches sideband addressing
// - Bits 24-31 queue depth; 10-23 reserved
// - Indirect select then data performs region access
// - Base zero: control regs, memory, relocatable
// - Bases one, two: apertures, memory, relocatable
// - Hold limit bounds bus ownership in clocks
// - Line size stored, never affects behaviour
// - Interrupt routing byte read/write, no effect
`timescale 1ns/1ps
module pcs_config_space import pcs_pkg::*; (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic ROM_STRAP,
   input wire logic AGP_STRAP,
   input wire logic CFG_REQ,
   input wire logic CFG_WE,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [3:0] CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   output logic CFG_ACK,
   input wire logic MASTER_TGT_ABORT,
   input wire logic MASTER_MST_ABORT,
   input wire logic MASTER_OWNS_BUS,
   output logic MASTER_HOLD_EXPIRED,
   output logic IND_REQ,
   output logic IND_WE,
   output logic [1:0] IND_REGION,
   output logic [23:0] IND_OFFSET,
   output logic [31:0] IND_WDATA,
   input wire logic [31:0] IND_RDATA,
   input wire logic IND_ACK,
   output logic SIDEBAND_ADDR_ON,
   output logic [7:0] REQUEST_QUEUE_DEPTH,
   output logic [31:0] CONTROL_BASE,
   output logic [31:0] APER1_BASE,
   output logic [31:0] APER2_BASE,
   input wire logic [7:0] ROM_DATA,
   output logic [15:0] ROM_ADDR,
   output logic ROM_RD
);

   // Whole register-bank state
   typedef struct packed {
      logic [1:0] strap_s1;                    // Strap sync stage one
      logic [1:0] strap_s2;                    // Strap sync stage two: {agp, rom}
      logic tgt_abort;                         // Status bit 12
      logic mst_abort;                         // Status bit 13
      logic [15:0] vendor;                     // Board vendor code
      logic [15:0] ident;                      // Board ident code
      logic vendor_wr;                         // Vendor code already written
      logic ident_wr;                          // Ident code already written
      logic [7:0] line_size;                   // Line size in words
      logic [7:0] hold_limit;                  // Master hold limit in clocks
      logic [7:0] irq_line;                    // Interrupt routing byte
      logic [31-BAR0_SIZE_LOG2:0] bar0;        // Control space base
      logic [31-APER_SIZE_LOG2:0] bar1;        // Aperture one base
      logic [31-APER_SIZE_LOG2:0] bar2;        // Aperture two base
      logic sba;                               // Sideband addressing on
      logic [7:0] rq_depth;                    // Request queue depth
      logic [1:0] region;                      // Indirect region
      logic [23:0] offset;                     // Indirect offset
      logic busy;                              // Indirect access in flight
      logic ind_req;                           // Indirect request
      logic ind_we;                            // Indirect write
      logic [31:0] ind_wdata;                  // Indirect write data
      logic ack;                               // Config access answered
      logic [31:0] rdata;                      // Config read data
      logic owned_d;                           // Bus ownership last cycle
      logic [7:0] hold_cnt;                    // Remaining hold clocks
      logic hold_expired;                      // Hold limit reached
   } pcs_state_t;

   pcs_state_t r_ff;
   pcs_state_t nxt_r;

   logic ld_done;                             // Loader finished pulse
   logic [15:0] ld_vendor;                    // Loaded vendor code
   logic [15:0] ld_ident;                     // Loaded ident code

   // Byte-lane merge of a 32-bit write
   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Identity bytes from ROM after reset
   pcs_rom_loader u_loader (
      .clk(CORE_CLK),
      .rst(RST),
      .start(r_ff.strap_s2[0]),
      .rom_data(ROM_DATA),
      .rom_addr(ROM_ADDR),
      .rom_rd(ROM_RD),
      .done(ld_done),
      .vendor(ld_vendor),
      .ident(ld_ident)
   );

   logic [15:0] status_word;                  // Assembled status word
   logic [31:0] rd_val;                       // Read mux result
   logic [31:0] wmerge;                       // Merged write value
   logic take;                                // Request accepted
   logic clr_tgt;                             // Clear target abort
   logic clr_mst;                             // Clear master abort
   logic rom_mode;                            // Identity comes from ROM

   // Next-state logic of the whole bank
   always_comb begin
      nxt_r = r_ff;
      nxt_r.ack = 1'b0;
      clr_tgt = 1'b0;
      clr_mst = 1'b0;
      nxt_r.strap_s1 = {AGP_STRAP, ROM_STRAP};
      nxt_r.strap_s2 = r_ff.strap_s1;
      rom_mode = r_ff.strap_s2[0];
      take = CFG_REQ && !r_ff.busy;
      // Fixed capability bits plus sticky aborts
      status_word = STATUS_FIXED;
      status_word[ST_TGT_ABORT] = r_ff.tgt_abort;
      status_word[ST_MST_ABORT] = r_ff.mst_abort;
      wmerge = '0;
      // Read mux; unmapped and reserved read zero
      case ({CFG_ADDR[7:2], 2'b00})
         OFS_CMD_STATUS: rd_val = {status_word, 16'h0000};
         OFS_LINE_TIMER: rd_val = {16'h0000, r_ff.hold_limit, r_ff.line_size};
         OFS_BAR0: rd_val = {r_ff.bar0, {BAR0_SIZE_LOG2{1'b0}}};   // Memory, 32-bit, no prefetch
         OFS_BAR1: rd_val = {r_ff.bar1, {APER_SIZE_LOG2{1'b0}}};
         OFS_BAR2: rd_val = {r_ff.bar2, {APER_SIZE_LOG2{1'b0}}};
         OFS_BOARD: rd_val = {r_ff.ident, r_ff.vendor};
         OFS_CAP_START: rd_val = {24'h000000, OFS_AGP_REV};
         OFS_IRQ: rd_val = {24'h000000, r_ff.irq_line};
         OFS_AGP_REV: begin
            // Major follows strap, next link zero
            rd_val = {8'h00, r_ff.strap_s2[1] ? AGP_MAJOR_ON : AGP_MAJOR_OFF, AGP_MINOR,
                      NEXT_LINK_NONE, CAP_ID_AGP};
         end
         OFS_AGP_CMD: rd_val = {r_ff.rq_depth, 14'h0000, r_ff.sba, 9'h000};
         OFS_IND_SEL: rd_val = {6'h00, r_ff.region, r_ff.offset};
         default: rd_val = 32'h0000_0000;
      endcase
      // Register writes
      if (take && CFG_WE) begin
         case ({CFG_ADDR[7:2], 2'b00})
            OFS_CMD_STATUS: begin
               // Ones clear, zeros
               clr_tgt = CFG_BE[3] && CFG_WDATA[STATUS_LANE_LSB + ST_TGT_ABORT];
               clr_mst = CFG_BE[3] && CFG_WDATA[STATUS_LANE_LSB + ST_MST_ABORT];
            end
            OFS_LINE_TIMER: begin
               // Line size only stored
               if (CFG_BE[0]) begin
                  nxt_r.line_size = CFG_WDATA[7:0];
               end
               if (CFG_BE[1]) begin
                  nxt_r.hold_limit = CFG_WDATA[15:8];
               end
            end
            OFS_BAR0: begin
               wmerge = merge32({r_ff.bar0, {BAR0_SIZE_LOG2{1'b0}}}, CFG_WDATA, CFG_BE);
               nxt_r.bar0 = wmerge[31:BAR0_SIZE_LOG2];
            end
            OFS_BAR1: begin
               wmerge = merge32({r_ff.bar1, {APER_SIZE_LOG2{1'b0}}}, CFG_WDATA, CFG_BE);
               nxt_r.bar1 = wmerge[31:APER_SIZE_LOG2];
            end
            OFS_BAR2: begin
               wmerge = merge32({r_ff.bar2, {APER_SIZE_LOG2{1'b0}}}, CFG_WDATA, CFG_BE);
               nxt_r.bar2 = wmerge[31:APER_SIZE_LOG2];
            end
            OFS_BOARD: begin
               wmerge = merge32({r_ff.ident, r_ff.vendor}, CFG_WDATA, CFG_BE);
               // One write each, strap mode only
               if (!rom_mode && !r_ff.vendor_wr && |CFG_BE[1:0]) begin
                  nxt_r.vendor = wmerge[15:0];
                  nxt_r.vendor_wr = 1'b1;
               end
               if (!rom_mode && !r_ff.ident_wr && |CFG_BE[3:2]) begin
                  nxt_r.ident = wmerge[31:16];
                  nxt_r.ident_wr = 1'b1;
               end
            end
            OFS_IRQ: begin
               // Stored for software only
               if (CFG_BE[0]) begin
                  nxt_r.irq_line = CFG_WDATA[7:0];
               end
            end
            OFS_AGP_CMD: begin
               if (CFG_BE[1]) begin
                  nxt_r.sba = CFG_WDATA[AGP_SBA_BIT];
               end
               if (CFG_BE[3]) begin
                  nxt_r.rq_depth = CFG_WDATA[AGP_RQ_LSB +: 8];
               end
            end
            OFS_IND_SEL: begin
               // Region and offset for the window
               wmerge = merge32({6'h00, r_ff.region, r_ff.offset}, CFG_WDATA, CFG_BE);
               nxt_r.region = wmerge[IND_REGION_LSB +: 2];
               nxt_r.offset = wmerge[23:0];
            end
            default: begin
               nxt_r.ack = 1'b0;
            end
         endcase
      end
      // Answer or launch an indirect access
      if (take) begin
         if ({CFG_ADDR[7:2], 2'b00} == OFS_IND_DATA) begin
            nxt_r.busy = 1'b1;
            nxt_r.ind_req = 1'b1;
            nxt_r.ind_we = CFG_WE;
            nxt_r.ind_wdata = CFG_WDATA;
         end else begin
            nxt_r.ack = 1'b1;
            nxt_r.rdata = CFG_WE ? r_ff.rdata : rd_val;
         end
      end
      // Indirect access completes
      if (r_ff.ind_req && IND_ACK) begin
         nxt_r.ind_req = 1'b0;
         nxt_r.busy = 1'b0;
         nxt_r.ack = 1'b1;
         nxt_r.rdata = r_ff.ind_we ? r_ff.rdata : IND_RDATA;
      end
      // Identity loaded from ROM
      if (ld_done) begin
         nxt_r.vendor = ld_vendor;
         nxt_r.ident = ld_ident;
      end
      // Sticky aborts, a new event beats a clear
      nxt_r.tgt_abort = MASTER_TGT_ABORT || (r_ff.tgt_abort && !clr_tgt);
      nxt_r.mst_abort = MASTER_MST_ABORT || (r_ff.mst_abort && !clr_mst);
      // Hold limit counted from the grant
      nxt_r.owned_d = MASTER_OWNS_BUS;
      if (MASTER_OWNS_BUS && !r_ff.owned_d) begin
         nxt_r.hold_cnt = r_ff.hold_limit;
      end else if (MASTER_OWNS_BUS && r_ff.hold_cnt != 8'h00) begin
         nxt_r.hold_cnt = r_ff.hold_cnt - 8'h01;
      end
      nxt_r.hold_expired = MASTER_OWNS_BUS && r_ff.owned_d && (r_ff.hold_cnt == 8'h00);
   end

   // State register; reset restores every value
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         r_ff <= '0;
         r_ff.vendor <= CHIP_VENDOR_ID;
         r_ff.ident <= CHIP_DEVICE_ID;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from the state register
   assign CFG_RDATA = r_ff.rdata;
   assign CFG_ACK = r_ff.ack;
   assign MASTER_HOLD_EXPIRED = r_ff.hold_expired;
   assign IND_REQ = r_ff.ind_req;
   assign IND_WE = r_ff.ind_we;
   assign IND_REGION = r_ff.region;
   assign IND_OFFSET = r_ff.offset;
   assign IND_WDATA = r_ff.ind_wdata;
   assign SIDEBAND_ADDR_ON = r_ff.sba;
   assign REQUEST_QUEUE_DEPTH = r_ff.rq_depth;
   assign CONTROL_BASE = {r_ff.bar0, {BAR0_SIZE_LOG2{1'b0}}};
   assign APER1_BASE = {r_ff.bar1, {APER_SIZE_LOG2{1'b0}}};
   assign APER2_BASE = {r_ff.bar2, {APER_SIZE_LOG2{1'b0}}};

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   logic rd_req;                              // Direct read taken
   assign rd_req = CFG_REQ && !r_ff.busy && !CFG_WE;

   abort_set_a: assert property (MASTER_TGT_ABORT |=> r_ff.tgt_abort)
      else $error("Target abort not recorded");
   abort_clear_a: assert property (CFG_REQ && !r_ff.busy && CFG_WE && CFG_ADDR == OFS_CMD_STATUS
      && CFG_BE[3] && CFG_WDATA[29] && !MASTER_MST_ABORT |=> !r_ff.mst_abort)
      else $error("Master abort not cleared by one");
   vendor_once_a: assert property (r_ff.vendor_wr && !ld_done |=> $stable(r_ff.vendor))
      else $error("Vendor code changed after its one write");
   cap_start_a: assert property (rd_req && CFG_ADDR == OFS_CAP_START |=> CFG_ACK && CFG_RDATA == 32'h40)
      else $error("Capability start wrong");
   agp_rev_a: assert property (rd_req && CFG_ADDR == OFS_AGP_REV |=> CFG_RDATA[15:8] == 8'h00
      && CFG_RDATA[19:16] == 4'h0 && CFG_RDATA[23:20] == {3'b000, $past(r_ff.strap_s2[1])})
      else $error("AGP revision word wrong");
   sideband_a: assert property (CFG_REQ && !r_ff.busy && CFG_WE && CFG_ADDR == OFS_AGP_CMD && CFG_BE[1]
      |=> SIDEBAND_ADDR_ON == $past(CFG_WDATA[9]))
      else $error("Sideband enable not taken from bit 9");
   indirect_go_a: assert property (CFG_REQ && !r_ff.busy && CFG_ADDR == OFS_IND_DATA
      |=> IND_REQ && IND_WE == $past(CFG_WE) && !CFG_ACK)
      else $error("Indirect access not launched");
   base_low_a: assert property (CFG_REQ && !r_ff.busy && CFG_WE && CFG_ADDR == OFS_BAR0 && CFG_BE == 4'hf
      |=> CONTROL_BASE[31:BAR0_SIZE_LOG2] == $past(CFG_WDATA[31:BAR0_SIZE_LOG2])
      && CONTROL_BASE[BAR0_SIZE_LOG2-1:0] == '0 && APER1_BASE[APER_SIZE_LOG2-1:0] == '0)
      else $error("Base address not taken or type bits not zero");
   hold_a: assert property (MASTER_OWNS_BUS && !r_ff.owned_d && r_ff.hold_limit == 8'h03
      ##1 MASTER_OWNS_BUS [*4] |=> MASTER_HOLD_EXPIRED)
      else $error("Hold limit not enforced");
   status_fixed_a: assert property (rd_req && CFG_ADDR == OFS_CMD_STATUS
      |=> (CFG_RDATA & 32'hcfff_ffff) == 32'h0280_0000)
      else $error("Fixed status bits wrong");

   indirect_c: cover property (IND_REQ && IND_ACK && !IND_WE);
   clear_c: cover property (r_ff.tgt_abort ##1 !r_ff.tgt_abort);
   load_c: cover property (ld_done);

endmodule // pcs_config_space

// ===== verification/pcs_far_model.sv
// Far-side model: ROM byte pins and the indirect region target.
// Assumes the bank's bus clock; answers indirect requests slowly.
`timescale 1ns/1ps
module pcs_far_model (
   input wire logic clk,
   input wire logic IND_REQ,
   input wire logic [1:0] IND_REGION,
   input wire logic [23:0] IND_OFFSET,
   input wire logic ROM_RD,
   input wire logic [15:0] ROM_ADDR,
   output logic IND_ACK = 1'b0,
   output logic [31:0] IND_RDATA,
   output logic [7:0] ROM_DATA
);
   logic [2:0] wait_ff = 3'h0; // Answer delay
   logic [31:0] word; // Word at the selected place
   assign word = {6'h00, IND_REGION, IND_OFFSET};
   // Idle lines show the inverse, never stale data
   assign IND_RDATA = IND_ACK ? word : ~word;
   assign ROM_DATA = ROM_RD ? ROM_ADDR[7:0] ^ 8'h5a : ROM_ADDR[7:0] ^ 8'ha5;
   // One answer per request, three cycles late
   always @(posedge clk) begin
      wait_ff <= (IND_REQ && !IND_ACK) ? wait_ff + 3'h1 : 3'h0;
      IND_ACK <= IND_REQ && !IND_ACK && wait_ff == 3'h2;
   end
endmodule // pcs_far_model

// ===== verification/pcs_config_space_test.sv
// Testbench: configuration cycles with expected values.
// Assumes the far-side model for ROM and indirect traffic.
`timescale 1ns/1ps
module pcs_config_space_test import pcs_pkg::*;;
   logic CORE_CLK = 1'b0, RST = 1'b1, ROM_STRAP = 1'b0, AGP_STRAP = 1'b1, CFG_REQ = 1'b0, CFG_WE = 1'b0;
   logic MASTER_TGT_ABORT = 1'b0, MASTER_MST_ABORT = 1'b0, MASTER_OWNS_BUS = 1'b0;
   logic [7:0] CFG_ADDR = 8'h00;
   logic [3:0] CFG_BE = 4'h0;
   logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA, IND_WDATA, IND_RDATA, CONTROL_BASE, APER1_BASE, APER2_BASE, rd;
   logic CFG_ACK, MASTER_HOLD_EXPIRED, IND_REQ, IND_WE, IND_ACK, SIDEBAND_ADDR_ON, ROM_RD;
   logic [1:0] IND_REGION;
   logic [23:0] IND_OFFSET;
   logic [7:0] REQUEST_QUEUE_DEPTH, ROM_DATA;
   logic [15:0] ROM_ADDR;
   int failures = 0, check_count = 0;
   pcs_config_space i_pcs_config_space (.CORE_CLK, .RST, .ROM_STRAP, .AGP_STRAP, .CFG_REQ, .CFG_WE, .CFG_ADDR,
      .CFG_BE, .CFG_WDATA, .CFG_RDATA, .CFG_ACK, .MASTER_TGT_ABORT, .MASTER_MST_ABORT, .MASTER_OWNS_BUS,
      .MASTER_HOLD_EXPIRED, .IND_REQ, .IND_WE, .IND_REGION, .IND_OFFSET, .IND_WDATA, .IND_RDATA, .IND_ACK,
      .SIDEBAND_ADDR_ON, .REQUEST_QUEUE_DEPTH, .CONTROL_BASE, .APER1_BASE, .APER2_BASE, .ROM_DATA, .ROM_ADDR, .ROM_RD);
   pcs_far_model i_pcs_far_model (.clk(CORE_CLK), .IND_REQ, .IND_REGION, .IND_OFFSET, .ROM_RD, .ROM_ADDR,
      .IND_ACK, .IND_RDATA, .ROM_DATA);
   // 125 MHz bus clock
   always #4 CORE_CLK = ~CORE_CLK;
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Value comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One configuration cycle; waits bounded for the answer
   task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      int n;
      @(posedge CORE_CLK);
      CFG_REQ <= 1'b1;
      CFG_WE <= we;
      CFG_ADDR <= a;
      CFG_BE <= be;
      CFG_WDATA <= d;
      @(posedge CORE_CLK);
      CFG_REQ <= 1'b0;
      #1;
      for (n = 0; n < 40 && CFG_ACK !== 1'b1; n++) @(posedge CORE_CLK) #1;
      if (n == 40) begin
         failures++;
         final_report();
      end
      rd = CFG_RDATA;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 4'hf, 32'h0);
      chk(rd, exp);
   endtask
   // Reset with chosen straps, then let the loader finish
   task automatic reset_dut(input logic rom, input logic agp);
      @(posedge CORE_CLK);
      RST <= 1'b1;
      ROM_STRAP <= rom;
      AGP_STRAP <= agp;
      repeat (16) @(posedge CORE_CLK);
      RST <= 1'b0;
      repeat (80) @(posedge CORE_CLK);
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      failures++;
      final_report();
   end
   initial begin
      logic [31:0] v;
      reset_dut(1'b0, 1'b1);
      rchk(OFS_CAP_START, {24'h0, OFS_AGP_REV});
      rchk(OFS_AGP_REV, {8'h0, AGP_MAJOR_ON, AGP_MINOR, NEXT_LINK_NONE, CAP_ID_AGP});
      rchk(OFS_BOARD, {CHIP_DEVICE_ID, CHIP_VENDOR_ID});
      acc(1'b1, OFS_BOARD, 4'hf, 32'h5678_9abc);
      acc(1'b1, OFS_BOARD, 4'hf, 32'h0);
      rchk(OFS_BOARD, 32'h5678_9abc);
      // Both aborts at once, then clear one
      @(posedge CORE_CLK);
      MASTER_TGT_ABORT <= 1'b1;
      MASTER_MST_ABORT <= 1'b1;
      @(posedge CORE_CLK);
      MASTER_TGT_ABORT <= 1'b0;
      MASTER_MST_ABORT <= 1'b0;
      rchk(OFS_CMD_STATUS, {STATUS_FIXED | 16'h3000, 16'h0});
      acc(1'b1, OFS_CMD_STATUS, 4'h8, 32'h1000_0000);
      rchk(OFS_CMD_STATUS, {STATUS_FIXED | 16'h2000, 16'h0});
      acc(1'b1, OFS_CMD_STATUS, 4'hf, 32'hffff_ffff);
      rchk(OFS_CMD_STATUS, {STATUS_FIXED, 16'h0});
      // Control word both ways
      for (int i = 0; i < 2; i++) begin
         v = i == 0 ? 32'hffff_ffff : 32'h5a00_0000;
         acc(1'b1, OFS_AGP_CMD, 4'hf, v);
         rchk(OFS_AGP_CMD, v & 32'hff00_0200);
         chk({SIDEBAND_ADDR_ON, REQUEST_QUEUE_DEPTH}, {v[9], v[31:24]});
      end
      for (int i = 0; i < 3; i++) acc(1'b1, OFS_BAR0 + 8'(4 * i), 4'hf, 32'hffff_ffff);
      chk(CONTROL_BASE, 32'hffff_ffff << BAR0_SIZE_LOG2);
      chk(APER1_BASE, 32'hffff_ffff << APER_SIZE_LOG2);
      rchk(OFS_BAR2, 32'hffff_ffff << APER_SIZE_LOG2);
      acc(1'b1, OFS_IRQ, 4'h1, 32'h0000_00c3);
      acc(1'b0, OFS_IRQ, 4'hf, 32'h0);
      chk(rd & 32'hff, 32'hc3);
      // Every region code through the window
      for (int r = 0; r < 4; r++) begin
         acc(1'b1, OFS_IND_SEL, 4'hf, {6'h0, 2'(r), 24'h00_0abc});
         rchk(OFS_IND_DATA, {6'h0, 2'(r), 24'h00_0abc});
      end
      // Indirect write: data, direction and place appear on the bank's indirect outputs
      acc(1'b1, OFS_IND_DATA, 4'hf, 32'hc0de_0001);
      chk(IND_WDATA, 32'hc0de_0001);
      chk({IND_WE, IND_REGION, IND_OFFSET}, {1'b1, 2'h3, 24'h00_0abc});
      // Hold limit 3: expiry from the fifth cycle of ownership
      acc(1'b1, OFS_LINE_TIMER, 4'h2, 32'h0000_0300);
      @(posedge CORE_CLK);
      MASTER_OWNS_BUS <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      #1 chk(MASTER_HOLD_EXPIRED, 1'b0);
      @(posedge CORE_CLK);
      MASTER_OWNS_BUS <= 1'b0;
      #1 chk(MASTER_HOLD_EXPIRED, 1'b1);
      repeat (2) @(posedge CORE_CLK);
      #1 chk(MASTER_HOLD_EXPIRED, 1'b0);
      reset_dut(1'b1, 1'b0);
      rchk(OFS_BOARD, 32'ha5a4_a7a6);
      // ROM mode: identity writes are ignored
      acc(1'b1, OFS_BOARD, 4'hf, 32'h0);
      rchk(OFS_BOARD, 32'ha5a4_a7a6);
      chk(CONTROL_BASE, 32'h0);
      rchk(OFS_AGP_REV, {8'h0, AGP_MAJOR_OFF, AGP_MINOR, NEXT_LINK_NONE, CAP_ID_AGP});
      rchk(OFS_AGP_CMD, 32'h0);
      rchk(OFS_CMD_STATUS, {STATUS_FIXED, 16'h0});
      final_report();
   end
endmodule // pcs_config_space_test
